// ---- lbc_top.sv ----
// Lookahead-carry binary counter with AXI4-Lite register access
// What this block does
// [RULE1] Terminal-count reset acts synchronously, only at the next clock edge.
// [RULE2] Terminal count is the AND of all counter bits; all ones. small_terminal_count shows the small counter's AND one cycle late.
// [RULE3] A bit toggles when enabled, not reset or loading, lower bits ones.
// [RULE4] Parallel enable loads the input word instead of counting.
// [RULE5] Clock enable, reset and parallel enable may each be left out.
// [RULE6] Ten-bit up-counter with count enable, direct clear, one clock.
// [RULE7] Direct clear asynchronously clears every flip-flop of the ten-bit counter.
// [RULE8] Low-group carry is bits 0-2 AND enable; drives bits 3-5.
// [RULE9] Mid-group carry bits 3-6; bits 7-9 add bit 7, bit 8.
// [RULE10] Four-bit counter preloads 0100 asynchronously before counting.
// [RULE11] Initial value may also be preloaded synchronously at an edge.
// [RULE12] Global reset low clears all counter registers.
// [RULE13] Counter steps through all states and wraps from ones to zero.
// [RULE14] Fully synchronous lookahead counting; no ripple stages.
// [RULE15] Reset wins over parallel load at the same edge.
`timescale 1ns/1ps
module lbc_top import lbc_pkg::*; #(
	parameter bit HAS_CE = 1'b1,
	parameter bit HAS_RST = 1'b1,
	parameter bit HAS_PE = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic direct_clear_n,
	input wire logic preload_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [CNT_W-1:0] count_q,
	output logic terminal_count,
	output logic [SMALL_W-1:0] small_q,
	output logic small_terminal_count
);
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic [3:0] ctrl_r;
	logic [CNT_W-1:0] load_r;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;
	logic tc_r;
	logic small_tc_r;
	logic [SMALL_W-1:0] small_value;

	// Write channel: address and data are taken together in one cycle
	wire wr_go = s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
	wire [ADDR_W-1:0] wa = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
	wire wr_ctrl = wr_go & (wa == ADDR_CTRL) & s_axi_wstrb[0];
	wire wr_load_lo = wr_go & (wa == ADDR_LOAD) & s_axi_wstrb[0];
	wire wr_load_hi = wr_go & (wa == ADDR_LOAD) & s_axi_wstrb[1];
	wire wr_cmd = wr_go & (wa == ADDR_CMD) & s_axi_wstrb[0];
	wire wr_known = (wa == ADDR_CTRL) | (wa == ADDR_LOAD) | (wa == ADDR_CMD);

	// Read channel decode
	wire rd_go = s_axi_arvalid & ~arready_r & ~rvalid_r;
	wire [ADDR_W-1:0] ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};
	wire rd_ctrl = ra == ADDR_CTRL;
	wire rd_load = ra == ADDR_LOAD;
	wire rd_cmd = ra == ADDR_CMD;
	wire rd_count = ra == ADDR_COUNT;
	wire rd_status = ra == ADDR_STATUS;
	wire rd_small = ra == ADDR_SMALL;
	wire rd_known = rd_ctrl | rd_load | rd_cmd | rd_count | rd_status | rd_small;
	wire [31:0] rd_word = rd_ctrl ? {28'h0000000, ctrl_r} :
		rd_load ? {22'h000000, load_r} :
		rd_count ? {22'h000000, count_r} :
		rd_status ? {30'h00000000, small_tc_r, tc_r} :
		rd_small ? {28'h0000000, small_value} : 32'h00000000;

	// Counter controls; a parameter set to zero removes that input
	wire cmd_rst = wr_cmd & s_axi_wdata[CMD_RST_BIT];
	wire cmd_load = wr_cmd & s_axi_wdata[CMD_LOAD_BIT];
	wire cmd_small_pre = wr_cmd & s_axi_wdata[CMD_SMALL_PRE_BIT];
	wire ce = HAS_CE ? ctrl_r[CTRL_CE_BIT] : 1'b1; // RULE5
	wire all_ones = &count_r; // RULE2
	wire small_all_ones = &small_value; // RULE2
	wire tc_rst = ctrl_r[CTRL_TCCLR_BIT] & all_ones & ce; // RULE1
	wire sync_rst = HAS_RST ? (cmd_rst | tc_rst) : 1'b0; // RULE5
	wire par_en = HAS_PE ? cmd_load : 1'b0; // RULE5
	wire tog_en = ce & ~sync_rst & ~par_en; // RULE3
	wire [CNT_W-1:0] toggle;
	wire low_group_carry;
	wire mid_group_carry;

	lbc_carry u_carry (
		.q(count_r),
		.en(tog_en),
		.toggle(toggle),
		.low_group_carry(low_group_carry),
		.mid_group_carry(mid_group_carry)
	);

	// Next state per bit: reset first, then load, then toggle
	genvar gi;
	generate
		for (gi = 0; gi < CNT_W; gi++) begin : g_bit
			assign count_nxt[gi] = sync_rst ? 1'b0 : // RULE15
				par_en ? load_r[gi] : // RULE4
				count_r[gi] ^ toggle[gi]; // RULE3
		end
	endgenerate

	// Counter flip-flops: direct clear is asynchronous, all else at the edge
	always_ff @(posedge aclk or negedge direct_clear_n) begin
		if (!direct_clear_n) begin
			count_r <= COUNT_RESET; // RULE7
		end else if (!aresetn) begin
			count_r <= COUNT_RESET; // RULE12
		end else begin
			count_r <= count_nxt; // RULE6 RULE14
		end
	end

	// Terminal count flags registered for the outputs
	always_ff @(posedge aclk or negedge direct_clear_n) begin
		if (!direct_clear_n) begin
			tc_r <= 1'b0;
		end else if (!aresetn) begin
			tc_r <= 1'b0;
		end else begin
			tc_r <= &count_nxt; // RULE2
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			small_tc_r <= 1'b0;
		end else begin
			small_tc_r <= small_all_ones; // RULE2
		end
	end

	lbc_small4 u_small (
		.aclk(aclk),
		.aresetn(aresetn),
		.preload_n(preload_n),
		.enable(ctrl_r[CTRL_SMALL_EN_BIT]),
		.sync_preload(cmd_small_pre),
		.tc_clear_en(ctrl_r[CTRL_SMALL_TCCLR_BIT]),
		.value_r(small_value)
	);

	// Software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r <= s_axi_wdata[3:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			load_r <= LOAD_RESET;
		end else begin
			load_r[7:0] <= wr_load_lo ? s_axi_wdata[7:0] : load_r[7:0];
			load_r[CNT_W-1:8] <= wr_load_hi ? s_axi_wdata[CNT_W-1:8] : load_r[CNT_W-1:8];
		end
	end

	// Write handshake and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			awready_r <= wr_go;
			wready_r <= wr_go;
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Read handshake and data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h00000000;
		end else begin
			arready_r <= rd_go;
			if (rd_go) begin
				rvalid_r <= 1'b1;
				rresp_r <= rd_known ? RESP_OKAY : RESP_SLVERR;
				rdata_r <= rd_word;
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// Outputs all come from flip-flops
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign count_q = count_r;
	assign terminal_count = tc_r;
	assign small_q = small_value;
	assign small_terminal_count = small_tc_r;

	// Checks on counter behaviour
	sequence s_load_edge;
		par_en && !sync_rst;
	endsequence
	sequence s_loaded;
		##1 count_r == $past(load_r);
	endsequence
	sequence s_wr_taken;
		wr_go;
	endsequence
	sequence s_wr_answer;
		##1 awready_r && wready_r && bvalid_r;
	endsequence
	sequence s_rd_taken;
		rd_go;
	endsequence
	sequence s_rd_answer;
		##1 arready_r && rvalid_r;
	endsequence

	// Bits that a plain increment would flip, to hold the carry groups against
	wire [CNT_W-1:0] inc_mask = count_r ^ (count_r + 10'h001);

	a_count_incr: assert property (@(posedge aclk) disable iff (!aresetn || !direct_clear_n) // RULE3
		(tog_en && !all_ones) |=> count_r == $past(count_r) + 10'h001)
		else $error("counter did not step by one");
	a_count_hold: assert property (@(posedge aclk) disable iff (!aresetn || !direct_clear_n) // RULE3
		(!tog_en && !sync_rst && !par_en) |=> $stable(count_r))
		else $error("counter moved while disabled");
	a_par_load: assert property (@(posedge aclk) disable iff (!aresetn || !direct_clear_n) // RULE4
		s_load_edge |-> s_loaded)
		else $error("parallel load value not taken");
	a_rst_prio: assert property (@(posedge aclk) disable iff (!aresetn || !direct_clear_n) // RULE15
		(sync_rst && par_en) |=> count_r == COUNT_RESET)
		else $error("reset did not win over load");
	a_tc_flag: assert property (@(posedge aclk) disable iff (!aresetn || !direct_clear_n) // RULE2
		tc_r == all_ones)
		else $error("terminal count flag wrong");
	a_wrap_zero: assert property (@(posedge aclk) disable iff (!aresetn || !direct_clear_n) // RULE13
		(all_ones && tog_en) |=> count_r == COUNT_RESET)
		else $error("counter did not wrap to zero");
	a_low_carry: assert property (@(posedge aclk) disable iff (!aresetn || !direct_clear_n) // RULE8
		low_group_carry |=> count_r[2:0] == 3'h0 && count_r[3] != $past(count_r[3]))
		else $error("low group carry did not propagate");
	a_mid_carry: assert property (@(posedge aclk) disable iff (!aresetn || !direct_clear_n) // RULE9
		(low_group_carry && mid_group_carry) |=> count_r[6:0] == 7'h00 && count_r[7] != $past(count_r[7]))
		else $error("mid group carry did not toggle bit 7");
	a_gres_clear: assert property (@(posedge aclk) disable iff (!direct_clear_n) // RULE12
		!aresetn |=> count_r == COUNT_RESET && !tc_r)
		else $error("global reset did not clear counter");
	a_tc_sync_rst: assert property (@(posedge aclk) disable iff (!aresetn || !direct_clear_n) // RULE1
		(tc_rst && sync_rst) |=> count_r == COUNT_RESET)
		else $error("terminal count reset not at next edge");
	a_dclear: assert property (@(posedge aclk) !direct_clear_n |-> count_r == COUNT_RESET && !tc_r) // RULE7
		else $error("direct clear did not hold counter at zero");
	a_toggle_mask: assert property (@(posedge aclk) disable iff (!aresetn || !direct_clear_n) // RULE8 RULE9
		tog_en |-> toggle == inc_mask)
		else $error("lookahead toggle mask differs from increment");
	a_no_toggle: assert property (@(posedge aclk) disable iff (!aresetn || !direct_clear_n) // RULE3
		!tog_en |-> toggle == '0)
		else $error("a bit toggles while counting is blocked");
	a_cmd_clear: assert property (@(posedge aclk) disable iff (!aresetn || !direct_clear_n) // RULE1
		(cmd_rst && sync_rst) |=> count_r == COUNT_RESET)
		else $error("software reset did not clear at the next edge");
	a_small_tc: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
		1'b1 |=> small_tc_r == $past(small_all_ones))
		else $error("small terminal count flag wrong");

	// Register bus answers one cycle after a request is taken
	a_wr_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_wr_taken |-> s_wr_answer)
		else $error("write not answered one cycle after it was taken");
	a_rd_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_rd_taken |-> s_rd_answer)
		else $error("read not answered one cycle after it was taken");
endmodule

// ---- lbc_pkg.sv ----
// Package of constants for the lookahead binary counter block
package lbc_pkg;
	localparam int CNT_W = 10;
	localparam int SMALL_W = 4;
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_LOAD = 8'h04;
	localparam logic [7:0] ADDR_CMD = 8'h08;
	localparam logic [7:0] ADDR_COUNT = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_SMALL = 8'h14;
	localparam int CTRL_CE_BIT = 0;
	localparam int CTRL_TCCLR_BIT = 1;
	localparam int CTRL_SMALL_EN_BIT = 2;
	localparam int CTRL_SMALL_TCCLR_BIT = 3;
	localparam int CMD_RST_BIT = 0;
	localparam int CMD_LOAD_BIT = 1;
	localparam int CMD_SMALL_PRE_BIT = 2;
	localparam int STAT_TC_BIT = 0;
	localparam int STAT_SMALL_TC_BIT = 1;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [CNT_W-1:0] LOAD_RESET = 10'h000;
	localparam logic [CNT_W-1:0] COUNT_RESET = 10'h000;
	localparam logic [SMALL_W-1:0] SMALL_RESET = 4'h0;
	localparam logic [SMALL_W-1:0] SMALL_PRELOAD = 4'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- lbc_carry.sv ----
// Grouped lookahead-carry decode for the ten-bit counter
`timescale 1ns/1ps
module lbc_carry import lbc_pkg::*; (
	input wire logic [CNT_W-1:0] q,
	input wire logic en,
	output logic [CNT_W-1:0] toggle,
	output logic low_group_carry,
	output logic mid_group_carry
);
	logic mid_partial_carry;
	logic high_pair_carry;

	// Carry groups for bits 0-2, 3-6 and 7-8
	assign low_group_carry = q[0] & q[1] & q[2] & en; // RULE8
	assign mid_partial_carry = q[3] & q[4] & q[5]; // RULE9
	assign mid_group_carry = mid_partial_carry & q[6]; // RULE9
	assign high_pair_carry = q[7] & q[8]; // RULE9

	// Per-bit toggle terms, each the AND of every lower bit
	assign toggle[0] = en; // RULE3
	assign toggle[1] = en & q[0]; // RULE3
	assign toggle[2] = en & q[0] & q[1]; // RULE3
	assign toggle[3] = low_group_carry; // RULE8
	assign toggle[4] = low_group_carry & q[3]; // RULE8
	assign toggle[5] = low_group_carry & q[3] & q[4]; // RULE8
	assign toggle[6] = low_group_carry & mid_partial_carry; // RULE9
	assign toggle[7] = low_group_carry & mid_group_carry; // RULE9
	assign toggle[8] = low_group_carry & mid_group_carry & q[7]; // RULE9
	assign toggle[9] = low_group_carry & mid_group_carry & high_pair_carry; // RULE9
endmodule

// ---- lbc_small4.sv ----
// Four-bit example counter with asynchronous and synchronous preload
`timescale 1ns/1ps
module lbc_small4 import lbc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic preload_n,
	input wire logic enable,
	input wire logic sync_preload,
	input wire logic tc_clear_en,
	output logic [SMALL_W-1:0] value_r
);
	logic tc;
	logic tc_rst;
	logic [SMALL_W-1:0] value_nxt;

	// Terminal count and the synchronous reset it drives
	assign tc = &value_r; // RULE2
	assign tc_rst = tc_clear_en & tc & enable; // RULE1
	assign value_nxt = sync_preload ? SMALL_PRELOAD : // RULE11
		tc_rst ? SMALL_RESET : // RULE1
		enable ? value_r + 4'h1 : value_r;

	// Asynchronous preload forces 0100: three bits cleared, one set
	always_ff @(posedge aclk or negedge preload_n) begin
		if (!preload_n) begin
			value_r <= SMALL_PRELOAD; // RULE10
		end else if (!aresetn) begin
			value_r <= SMALL_RESET; // RULE12
		end else begin
			value_r <= value_nxt;
		end
	end

	a_small_preload: assert property (@(posedge aclk) !preload_n |-> value_r == SMALL_PRELOAD) // RULE10
		else $error("small counter not held at preload value");
	a_small_tcclr: assert property (@(posedge aclk) disable iff (!aresetn || !preload_n) // RULE1
		(tc && enable && tc_clear_en && !sync_preload) |=> value_r == SMALL_RESET)
		else $error("small counter did not clear after terminal count");
	a_small_sync: assert property (@(posedge aclk) disable iff (!aresetn || !preload_n) // RULE11
		sync_preload |=> value_r == SMALL_PRELOAD)
		else $error("synchronous preload not applied");
endmodule

// ---- lbc_top_tb.sv ----
// Self-checking testbench for the lookahead binary counter top level
`timescale 1ns/1ps
module lbc_top_tb import lbc_pkg::*;;
	logic aclk = 1'b0, aresetn = 1'b0, direct_clear_n = 1'b1, preload_n = 1'b1;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, tc, stc;
	logic [1:0] bresp, rresp, resp;
	logic [CNT_W-1:0] count_q;
	logic [SMALL_W-1:0] small_q;
	logic [31:0] rd, v;
	int num_errors = 0, total_checks = 0, cycles = 0, seed = 32'h5558, model = 0;
	// Clock at 25 MHz
	always #20 aclk = ~aclk;
	lbc_top lbc_top_i (.aclk(aclk), .aresetn(aresetn), .direct_clear_n(direct_clear_n),
		.preload_n(preload_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .count_q(count_q), .terminal_count(tc),
		.small_q(small_q), .small_terminal_count(stc));
	// Compare one value with its expectation
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Closing report and verdict
	task automatic results();
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// AXI4-Lite write; address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (bvalid !== 1'b1) @(posedge aclk);
		r = bresp;
		bready <= 1'b0;
	endtask
	// AXI4-Lite read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// Run the counter and compare every step with the reference increment
	task automatic count_run(input logic [31:0] mode);
		int prev;
		int wrapped;
		axi_wr(ADDR_LOAD, 32'h3F8, resp);
		axi_wr(ADDR_CMD, 32'h2, resp);
		axi_wr(ADDR_CTRL, mode, resp);
		repeat (2) @(posedge aclk);
		prev = count_q;
		wrapped = 0;
		repeat (20) begin
			@(posedge aclk);
			check(count_q, (prev + 1) % 1024);
			check(tc, count_q == 10'h3FF);
			if (prev == 1023)
				wrapped = 1;
			prev = count_q;
		end
		check(wrapped, 1);
		axi_wr(ADDR_CTRL, 32'h0, resp);
	endtask
	// Bounded run time
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles >= 20000) begin
			num_errors++;
			results();
		end
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check(count_q, COUNT_RESET);
		check(small_q, SMALL_RESET);
		axi_rd(ADDR_CTRL, rd, resp);
		check(rd, CTRL_RESET);
		// Parallel loads of random words, last one all ones
		for (int k = 0; k < 4; k++) begin
			v = (k == 3) ? 32'h3FF : ($random(seed) & 32'h3FF);
			axi_wr(ADDR_LOAD, v, resp);
			axi_wr(ADDR_CMD, 32'h2, resp);
			#1 check(count_q, v);
			axi_rd(ADDR_COUNT, rd, resp);
			check(rd, v);
			check(resp, RESP_OKAY);
		end
		#1 check(tc, 1'b1);
		axi_wr(ADDR_CMD, 32'h3, resp);
		#1 check(count_q, 10'h000);
		axi_wr(ADDR_CMD, 32'h2, resp);
		axi_wr(ADDR_CMD, 32'h1, resp);
		#1 check(count_q, 10'h000);
		count_run(32'h1);
		count_run(32'h3);
		// Direct clear acts without a clock edge
		axi_wr(ADDR_CMD, 32'h2, resp);
		@(posedge aclk);
		direct_clear_n <= 1'b0;
		#5 check(count_q, 10'h000);
		check(tc, 1'b0);
		@(posedge aclk);
		direct_clear_n <= 1'b1;
		// Second reset in mid-run clears the counter
		axi_wr(ADDR_CMD, 32'h2, resp);
		@(posedge aclk);
		aresetn <= 1'b0;
		@(posedge aclk);
		aresetn <= 1'b1;
		#1 check(count_q, 10'h000);
		// Asynchronous preload of the small counter
		@(posedge aclk);
		preload_n <= 1'b0;
		#5 check(small_q, SMALL_PRELOAD);
		@(posedge aclk);
		preload_n <= 1'b1;
		// Small counter steps from 0100 and wraps through the terminal-count clear
		axi_wr(ADDR_CTRL, 32'hC, resp);
		v = SMALL_PRELOAD;
		model = SMALL_PRELOAD;
		repeat (14) begin
			check(small_q, v);
			check(stc, model == 15);
			model = v;
			v = (v + 1) % 16;
			@(posedge aclk);
		end
		axi_wr(ADDR_CTRL, 32'h0, resp);
		axi_wr(ADDR_CMD, 32'h4, resp);
		#1 check(small_q, SMALL_PRELOAD);
		axi_rd(ADDR_SMALL, rd, resp);
		check(rd, SMALL_PRELOAD);
		// Unmapped place
		axi_wr(8'h20, 32'h1, resp);
		check(resp, RESP_SLVERR);
		axi_rd(8'h20, rd, resp);
		check(rd, 32'h0);
		check(resp, RESP_SLVERR);
		results();
	end
endmodule
